//--- eeprom_i2c_master.sv
// frame sequencer for eeprom write, read and burst read
`timescale 1ns/100ps
module eeprom_i2c_master (
  input  wire logic                  CLK_IN,
  input  wire logic                  RST_B_IN,
  input  wire logic                  REQ_VALID_IN,
  input  wire eeprom_i2c_pkg::req_t  REQ_IN,
  output logic                       REQ_READY_OUT,
  output eeprom_i2c_pkg::rdata_t     RDATA_OUT,
  output logic                       RDATA_VALID_OUT,
  output logic                       DONE_OUT,
  output logic                       NACK_ERR_OUT,
  input  wire logic                  SCL_IN,
  output logic                       SCL_OUT,
  output logic                       SCL_OE_OUT,
  input  wire logic                  SDA_IN,
  output logic                       SDA_OUT,
  output logic                       SDA_OE_OUT
);
  typedef enum logic [3:0] {
    S_IDLE  = 4'h0,
    S_START = 4'h1,
    S_INST  = 4'h2,
    S_ADRH  = 4'h3,
    S_ADRL  = 4'h4,
    S_WDAT  = 4'h5,
    S_RSTRT = 4'h6,
    S_RINST = 4'h7,
    S_RDAT  = 4'h8,
    S_STOP  = 4'h9,
    S_WAIT  = 4'hA
  } state_t;

  typedef struct packed {
    state_t                 st;
    state_t                 after;
    eeprom_i2c_pkg::req_t   req;
    logic [7:0]             left;
    logic                   err;
    logic                   ready;
    eeprom_i2c_pkg::rdata_t rd;
    logic                   rd_v;
    logic                   done;
    logic                   nack;
    logic                   scl_oe;
    logic                   sda_oe;
    eeprom_i2c_pkg::bop_t   bop;
    logic                   bop_v;
    logic [7:0]             tx;
    logic                   ackt;
  } st_t;
  st_t st_reg;
  st_t st_next;

  logic       tick;
  logic       eng_busy;
  logic       eng_done;
  logic [7:0] eng_rx;
  logic       eng_ack;
  logic       eng_scl;
  logic       eng_sda;
  logic [6:0] dev_addr;
  logic [7:0] adr_hi;
  logic [7:0] adr_lo;

  //////////////////////////////////////////////////////////////////////
  // address mapping

  always_comb begin
    dev_addr = {eeprom_i2c_pkg::DEV_FIXED, st_reg.req.sel};
    adr_hi = st_reg.req.addr[15:8];
    adr_lo = st_reg.req.addr[7:0];
    if (st_reg.req.mode16) begin
      // select bits purely from straps
      dev_addr[2:0] = st_reg.req.sel;
      case (st_reg.req.size)
        3'h0: adr_hi = {4'h0, st_reg.req.addr[11:8]};
        3'h1: adr_hi = {3'h0, st_reg.req.addr[12:8]};
        3'h2: adr_hi = {2'h0, st_reg.req.addr[13:8]};
        3'h3: adr_hi = {1'b0, st_reg.req.addr[14:8]};
        default: adr_hi = st_reg.req.addr[15:8];
      endcase
    end else begin
      case (st_reg.req.size)
        3'h0: adr_lo = {1'b0, st_reg.req.addr[6:0]};
        3'h1: adr_lo = st_reg.req.addr[7:0];
        3'h2: dev_addr[0] = st_reg.req.addr[8];
        3'h3: dev_addr[1:0] = st_reg.req.addr[9:8];
        default: dev_addr[2:0] = st_reg.req.addr[10:8];
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////
  // frame sequencer

  always_comb begin
    st_next = st_reg;
    st_next.bop_v = 1'b0;
    st_next.rd_v = 1'b0;
    st_next.done = 1'b0;
    st_next.scl_oe = eng_scl;
    st_next.sda_oe = eng_sda;
    case (st_reg.st)
      S_IDLE: begin
        st_next.ready = 1'b1;
        if (REQ_VALID_IN && st_reg.ready) begin
          st_next.req = REQ_IN;
          // burst only granted for firmware load
          if (REQ_IN.op == eeprom_i2c_pkg::OP_BURST && !REQ_IN.firmware) begin
            st_next.req.op = eeprom_i2c_pkg::OP_READ;
          end
          st_next.left = REQ_IN.count;
          st_next.err = 1'b0;
          st_next.ready = 1'b0;
          st_next.bop = eeprom_i2c_pkg::BOP_START;
          st_next.bop_v = 1'b1;
          st_next.st = S_WAIT;
          st_next.after = S_INST;
        end
      end
      S_WAIT: begin
        if (eng_done) begin
          st_next.st = st_reg.after;
        end
      end
      S_INST: begin
        st_next.tx = {dev_addr, 1'b0};
        st_next.bop = eeprom_i2c_pkg::BOP_WRITE;
        st_next.bop_v = 1'b1;
        st_next.st = S_WAIT;
        st_next.after = st_reg.req.mode16 ? S_ADRH : S_ADRL;
      end
      S_ADRH, S_ADRL, S_WDAT, S_RINST: begin
        // previous byte must have been acknowledged
        if (!eng_ack && st_reg.bop == eeprom_i2c_pkg::BOP_WRITE) begin
          st_next.err = 1'b1;
          st_next.bop = eeprom_i2c_pkg::BOP_STOP;
          st_next.bop_v = 1'b1;
          st_next.st = S_WAIT;
          st_next.after = S_STOP;
        end else begin
          st_next.bop = eeprom_i2c_pkg::BOP_WRITE;
          st_next.bop_v = 1'b1;
          st_next.st = S_WAIT;
          case (st_reg.st)
            S_ADRH: begin
              st_next.tx = adr_hi;
              st_next.after = S_ADRL;
            end
            S_ADRL: begin
              st_next.tx = adr_lo;
              st_next.after = (st_reg.req.op == eeprom_i2c_pkg::OP_WRITE)
                              ? S_WDAT : S_RSTRT;
            end
            S_WDAT: begin
              st_next.tx = st_reg.req.wdata;
              st_next.after = S_STOP;
            end
            default: begin
              st_next.tx = {dev_addr, 1'b1};
              st_next.after = S_RDAT;
            end
          endcase
        end
      end
      S_RSTRT: begin
        if (!eng_ack) begin
          st_next.err = 1'b1;
          st_next.bop = eeprom_i2c_pkg::BOP_STOP;
          st_next.after = S_STOP;
        end else begin
          // repeated start, no stop in between
          st_next.bop = eeprom_i2c_pkg::BOP_START;
          st_next.after = S_RINST;
        end
        st_next.bop_v = 1'b1;
        st_next.st = S_WAIT;
      end
      S_RDAT: begin
        if (st_reg.bop == eeprom_i2c_pkg::BOP_READ) begin
          st_next.rd.data = eng_rx;
          st_next.rd.last = (st_reg.left == 8'h00);
          st_next.rd_v = 1'b1;
        end
        if (st_reg.bop == eeprom_i2c_pkg::BOP_WRITE && !eng_ack) begin
          st_next.err = 1'b1;
          st_next.bop = eeprom_i2c_pkg::BOP_STOP;
          st_next.after = S_STOP;
        end else if (st_reg.bop == eeprom_i2c_pkg::BOP_READ
                     && st_reg.left == 8'h00) begin
          st_next.bop = eeprom_i2c_pkg::BOP_STOP;
          st_next.after = S_STOP;
        end else begin
          if (st_reg.bop == eeprom_i2c_pkg::BOP_READ) begin
            st_next.left = st_reg.left - 8'h01;
          end
          st_next.bop = eeprom_i2c_pkg::BOP_READ;
          // ack while more bytes wanted, nack on the last
          st_next.ackt = (st_reg.req.op == eeprom_i2c_pkg::OP_BURST)
                         && (st_next.left != 8'h00);
          st_next.after = S_RDAT;
          if (st_reg.req.op != eeprom_i2c_pkg::OP_BURST) begin
            st_next.left = 8'h00;
          end
        end
        st_next.bop_v = 1'b1;
        st_next.st = S_WAIT;
      end
      S_STOP: begin
        if (st_reg.bop != eeprom_i2c_pkg::BOP_STOP) begin
          st_next.bop = eeprom_i2c_pkg::BOP_STOP;
          st_next.bop_v = 1'b1;
          st_next.st = S_WAIT;
          st_next.after = S_STOP;
          st_next.err = st_reg.err | !eng_ack;
        end else begin
          st_next.done = 1'b1;
          st_next.nack = st_reg.err;
          st_next.st = S_IDLE;
        end
      end
      default: st_next.st = S_IDLE;
    endcase
  end

  always_ff @(posedge CLK_IN) begin
    if (!RST_B_IN) begin
      st_reg <= '{st: S_IDLE, after: S_IDLE, req: '0,
                  bop: eeprom_i2c_pkg::BOP_NONE, default: '0};
    end else begin
      st_reg <= st_next;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // engine and divider

  i2c_tick_gen u_tick (
    .clk_in   (CLK_IN),
    .rst_b_in (RST_B_IN),
    .run_in   (eng_busy),
    .tick_out (tick)
  );

  i2c_bit_engine u_eng (
    .clk_in       (CLK_IN),
    .rst_b_in     (RST_B_IN),
    .tick_in      (tick),
    .cmd_in       (st_reg.bop),
    .cmd_valid_in (st_reg.bop_v),
    .tx_in        (st_reg.tx),
    .ack_tx_in    (st_reg.ackt),
    .sda_in       (SDA_IN),
    .busy_out     (eng_busy),
    .done_out     (eng_done),
    .rx_out       (eng_rx),
    .ack_rx_out   (eng_ack),
    .scl_oe_out   (eng_scl),
    .sda_oe_out   (eng_sda)
  );

  assign REQ_READY_OUT   = st_reg.ready;
  assign RDATA_OUT       = st_reg.rd;
  assign RDATA_VALID_OUT = st_reg.rd_v;
  assign DONE_OUT        = st_reg.done;
  assign NACK_ERR_OUT    = st_reg.nack;
  assign SCL_OUT         = 1'b0;
  assign SCL_OE_OUT      = st_reg.scl_oe;
  assign SDA_OUT         = 1'b0;
  assign SDA_OE_OUT      = st_reg.sda_oe;
endmodule : eeprom_i2c_master

//--- eeprom_i2c_master_chk.sv
// port assertions for the eeprom i2c master
`timescale 1ns/100ps
module eeprom_i2c_master_chk (
  input  wire logic                   CLK_IN,
  input  wire logic                   RST_B_IN,
  input  wire logic                   REQ_VALID_IN,
  input  wire logic                   REQ_READY_OUT,
  input  wire eeprom_i2c_pkg::rdata_t RDATA_OUT,
  input  wire logic                   RDATA_VALID_OUT,
  input  wire logic                   DONE_OUT,
  input  wire logic                   NACK_ERR_OUT,
  input  wire logic                   SCL_OE_OUT,
  input  wire logic                   SDA_OE_OUT
);
  default clocking cb @(posedge CLK_IN);
  endclocking
  default disable iff (!RST_B_IN);
  ////////////////////////////////////////////////////////////////////////////
  property p_idle;
    REQ_READY_OUT |-> !SCL_OE_OUT && !SDA_OE_OUT;
  endproperty
  a_idle: assert property (p_idle)
    else $error("lines driven while idle");
  property p_take;
    REQ_VALID_IN && REQ_READY_OUT |=> !REQ_READY_OUT;
  endproperty
  a_take: assert property (p_take)
    else $error("ready still high after request taken");
  property p_start;
    REQ_VALID_IN && REQ_READY_OUT
      |-> ##[1:400] ($rose(SDA_OE_OUT) && !SCL_OE_OUT);
  endproperty
  a_start: assert property (p_start)
    else $error("no start condition after request");
  property p_stop;
    DONE_OUT |-> !SDA_OE_OUT && !SCL_OE_OUT;
  endproperty
  a_stop: assert property (p_stop)
    else $error("lines not released at frame end");
  property p_done_pulse;
    DONE_OUT |=> !DONE_OUT;
  endproperty
  a_done_pulse: assert property (p_done_pulse)
    else $error("done longer than one cycle");
  property p_rdv;
    RDATA_VALID_OUT |-> !REQ_READY_OUT ##1 !RDATA_VALID_OUT;
  endproperty
  a_rdv: assert property (p_rdv)
    else $error("read data pulse outside frame or too long");
  property p_rdata_hold;
    $changed(RDATA_OUT) |-> RDATA_VALID_OUT;
  endproperty
  a_rdata_hold: assert property (p_rdata_hold)
    else $error("read data changed without pulse");
  property p_nack_hold;
    $changed(NACK_ERR_OUT) |-> DONE_OUT;
  endproperty
  a_nack_hold: assert property (p_nack_hold)
    else $error("ack error flag changed without done");
  property p_ready_back;
    DONE_OUT |-> ##[0:4] REQ_READY_OUT;
  endproperty
  a_ready_back: assert property (p_ready_back)
    else $error("ready not back after done");
  c_nack: cover property (DONE_OUT && NACK_ERR_OUT);
  c_last: cover property (RDATA_VALID_OUT && RDATA_OUT.last);
  c_more: cover property (RDATA_VALID_OUT && !RDATA_OUT.last);
endmodule : eeprom_i2c_master_chk

bind eeprom_i2c_master eeprom_i2c_master_chk chk (
  .CLK_IN(CLK_IN), .RST_B_IN(RST_B_IN), .REQ_VALID_IN(REQ_VALID_IN),
  .REQ_READY_OUT(REQ_READY_OUT), .RDATA_OUT(RDATA_OUT),
  .RDATA_VALID_OUT(RDATA_VALID_OUT), .DONE_OUT(DONE_OUT),
  .NACK_ERR_OUT(NACK_ERR_OUT), .SCL_OE_OUT(SCL_OE_OUT),
  .SDA_OE_OUT(SDA_OE_OUT)
);

//--- eeprom_i2c_master_frames_test.sv
// self-checking bench for the eeprom i2c master frames
`timescale 1ns/100ps
module eeprom_i2c_master_frames_test;
  logic                   clk, rst_b, req_valid, m16;
  logic                   req_ready, rdata_valid, done, nack_err;
  logic                   scl_oe, sda_oe, eep_oe, scl_w, sda_w;
  logic                   scl_o, sda_o;
  logic [2:0]             msel;
  logic [9:0]             got;
  eeprom_i2c_pkg::req_t   req;
  eeprom_i2c_pkg::rdata_t rdata;
  logic [9:0]             exp_q[$];
  int                     err_count, tests_run, cycles;
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  assign scl_w = !scl_oe;
  assign sda_w = !(sda_oe || eep_oe);
  eeprom_i2c_master dut (
    .CLK_IN(clk), .RST_B_IN(rst_b), .REQ_VALID_IN(req_valid), .REQ_IN(req),
    .REQ_READY_OUT(req_ready), .RDATA_OUT(rdata),
    .RDATA_VALID_OUT(rdata_valid), .DONE_OUT(done),
    .NACK_ERR_OUT(nack_err), .SCL_IN(scl_w), .SCL_OUT(scl_o),
    .SCL_OE_OUT(scl_oe), .SDA_IN(sda_w), .SDA_OUT(sda_o), .SDA_OE_OUT(sda_oe)
  );
  eeprom_model eep (
    .clk_in(clk), .scl_in(scl_w), .sda_in(sda_w), .mode16_in(m16),
    .sel_in(msel), .sda_oe_out(eep_oe)
  );
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [9:0] e, input logic [9:0] s, string n);
    tests_run++;
    if (s !== e) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic test_done;
    if (err_count == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : test_done
  always @(negedge clk) begin
    got = done ? {1'b1, nack_err, 8'h00} : {1'b0, rdata.last, rdata.data};
    if (rdata_valid === 1'b1 || done === 1'b1) begin
      if (exp_q.size() == 0)
        chk(10'h3FF, got, "extra result");
      else
        chk(exp_q.pop_front(), got, "result");
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic frame(input eeprom_i2c_pkg::op_t op, input logic [15:0] a,
                       input logic [7:0] cnt, input logic [2:0] sz,
                       input logic fw, input logic bad);
    logic [7:0]  wq[$];
    logic [7:0]  ins, hi, lo, wd;
    logic [2:0]  s, dv;
    logic [15:0] p;
    int          nb, t;
    wd = 8'($urandom);
    s = 3'($urandom);
    msel = s ^ {2'b00, bad};
    for (int i = 0; i < 3; i++)
      dv[i] = (i < int'(sz) - 1) ? a[8 + i] : s[i];
    p = a & 16'((17'h1 << (12 + sz)) - 17'h1);
    if (!m16)
      p = {5'h00, dv, sz == 3'h0 ? {1'b0, a[6:0]} : a[7:0]};
    ins = {4'hA, m16 ? s : p[10:8], 1'b0};
    {hi, lo} = p;
    wq.push_back(ins);
    if (!bad) begin
      if (m16)
        wq.push_back(hi);
      wq.push_back(lo);
      wq.push_back(op == eeprom_i2c_pkg::OP_WRITE ? wd : ins | 8'h01);
      nb = (op == eeprom_i2c_pkg::OP_BURST && fw) ? int'(cnt) + 1 : 1;
      for (int j = 0; j < nb && op != eeprom_i2c_pkg::OP_WRITE; j++)
        exp_q.push_back({1'b0, j == nb - 1, 8'(p + j) ^ 8'((p + j) >> 8)
                         ^ 8'hC3});
    end
    exp_q.push_back({1'b1, bad, 8'h00});
    req = '{op:op, addr:a, wdata:wd, count:cnt, sel:s, mode16:m16,
            size:sz, firmware:fw};
    t = 0;
    while (req_ready !== 1'b1 && t < 50) begin
      @(negedge clk);
      t++;
    end
    req_valid = 1'b1;
    @(negedge clk);
    req_valid = 1'b0;
    t = 0;
    while (exp_q.size() != 0 && t < 30000) begin
      @(negedge clk);
      t++;
    end
    chk(10'h000, 10'(exp_q.size()), "pending results");
    exp_q.delete();
    chk(10'h000, {8'h00, scl_o, sda_o}, "drive level");
    chk(10'(wq.size()), 10'(eep.seen.size()), "byte count");
    foreach (wq[i])
      chk({2'b00, wq[i]}, {2'b00, eep.seen[i]}, "wire byte");
    eep.seen.delete();
  endtask : frame
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    cycles = 0;
    forever begin
      @(posedge clk);
      cycles++;
      if (cycles == 120000) begin
        err_count++;
        test_done();
      end
    end
  end
  initial begin
    {rst_b, req_valid, m16, msel, req} = '0;
    {err_count, tests_run} = '0;
    void'($urandom(32'hDED525A3));
    repeat (16) @(negedge clk);
    rst_b = 1'b1;
    @(negedge clk);
    for (int z = 0; z < 4; z++)
      frame(eeprom_i2c_pkg::OP_WRITE, 16'($urandom), 8'h00, 3'(z), 1'b0,
            1'b0);
    frame(eeprom_i2c_pkg::OP_BURST, 16'($urandom), 8'h02, 3'h4, 1'b0,
          1'b0);
    m16 = 1'b1;
    frame(eeprom_i2c_pkg::OP_WRITE, 16'($urandom), 8'h00,
          3'($urandom_range(4)), 1'b0, 1'b0);
    frame(eeprom_i2c_pkg::OP_BURST, 16'($urandom), 8'h01,
          3'($urandom_range(4)), 1'b1, 1'b0);
    frame(eeprom_i2c_pkg::OP_READ, 16'($urandom), 8'h00, 3'h0, 1'b0,
          1'b1);
    test_done();
  end
endmodule : eeprom_i2c_master_frames_test

//--- eeprom_i2c_pkg.sv
// package: constants and types for the eeprom i2c master
package eeprom_i2c_pkg;

  localparam int unsigned CLK_HZ        = 40_000_000;
  localparam int unsigned SCL_HZ        = 100_000;
  localparam int unsigned QTR_CYCLES    = CLK_HZ / (SCL_HZ * 4);
  localparam logic [3:0]  DEV_FIXED     = 4'hA;
  localparam logic [3:0]  SIZE_RESET    = 4'h0;
  localparam int unsigned BYTE_BITS     = 8;
  localparam logic [3:0]  LAST_BIT      = 4'h8;

  typedef enum logic [1:0] {
    OP_WRITE = 2'h0,
    OP_READ  = 2'h1,
    OP_BURST = 2'h2
  } op_t;

  // memory size code: 0=1kb 1=2kb 2=4kb 3=8kb 4=16kb (11-bit mode)
  typedef struct packed {
    op_t         op;
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic [7:0]  count;
    logic [2:0]  sel;
    logic        mode16;
    logic [2:0]  size;
    logic        firmware;
  } req_t;

  typedef struct packed {
    logic [7:0] data;
    logic       last;
  } rdata_t;

  typedef enum logic [2:0] {
    BOP_START = 3'h0,
    BOP_STOP  = 3'h1,
    BOP_WRITE = 3'h2,
    BOP_READ  = 3'h3,
    BOP_NONE  = 3'h4
  } bop_t;

endpackage : eeprom_i2c_pkg

//--- eeprom_model.sv
// behavioural i2c eeprom on the far side of the master
`timescale 1ns/100ps
module eeprom_model (
  input  wire logic       clk_in,
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  input  wire logic       mode16_in,
  input  wire logic [2:0] sel_in,
  output logic            sda_oe_out
);
  logic [7:0]  seen[$];
  logic        scl_q, sda_q, act, rd, go, ok, ia, hit;
  logic [3:0]  bc;
  logic [7:0]  sh, dat;
  logic [15:0] ptr;
  int          idx;
  assign dat = ptr[7:0] ^ ptr[15:8] ^ 8'hC3;
  // small parts take all three select bits as address bits
  assign hit = (sh[7:4] == 4'hA) && (!mode16_in || sh[3:1] == sel_in);
  initial begin
    {scl_q, sda_q, act, rd, go, ok, ia, sda_oe_out} = 8'hC0;
    {bc, sh, ptr} = 28'h0;
    idx = 0;
  end
  ////////////////////////////////////////////////////////////////////////////
  always @(posedge clk_in) begin
    scl_q <= scl_in;
    sda_q <= sda_in;
    if (scl_in && scl_q && sda_q && !sda_in) begin
      {act, bc, rd, go, ia} <= 8'h80;
      idx <= 0;
    end else if (scl_in && scl_q && !sda_q && sda_in) begin
      act <= 1'b0;
      sda_oe_out <= 1'b0;
    end else if (act && scl_in && !scl_q) begin
      if (bc == 4'h8) begin
        bc <= 4'h0;
        if (ia) begin
          {rd, go, ia} <= 3'b110;
        end else if (rd) begin
          go <= go && !sda_in;
          ptr <= ptr + 16'h1;
        end
      end else begin
        sh <= {sh[6:0], sda_in};
        bc <= bc + 4'h1;
      end
    end else if (act && !scl_in && scl_q) begin
      if (bc == 4'h8 && !rd) begin
        seen.push_back(sh);
        idx <= idx + 1;
        if (idx == 0) begin
          ok <= hit;
          ia <= sh[0] && hit;
          sda_oe_out <= hit;
          if (!mode16_in)
            ptr[15:8] <= {5'h00, sh[3:1]};
        end else begin
          sda_oe_out <= ok;
          if (idx == 1 && mode16_in)
            ptr[15:8] <= sh;
          else if (idx <= 1 + int'(mode16_in))
            ptr[7:0] <= sh;
        end
      end else if (rd && go && bc != 4'h8) begin
        sda_oe_out <= !dat[3'(4'h7 - bc)];
      end else begin
        sda_oe_out <= 1'b0;
      end
    end
  end
endmodule : eeprom_model

//--- i2c_bit_engine.sv
// byte level i2c engine: start, stop, byte write, byte read
`timescale 1ns/100ps
module i2c_bit_engine (
  input  wire logic                 clk_in,
  input  wire logic                 rst_b_in,
  input  wire logic                 tick_in,
  input  wire eeprom_i2c_pkg::bop_t cmd_in,
  input  wire logic                 cmd_valid_in,
  input  wire logic [7:0]           tx_in,
  input  wire logic                 ack_tx_in,
  input  wire logic                 sda_in,
  output logic                      busy_out,
  output logic                      done_out,
  output logic [7:0]                rx_out,
  output logic                      ack_rx_out,
  output logic                      scl_oe_out,
  output logic                      sda_oe_out
);
  typedef struct packed {
    eeprom_i2c_pkg::bop_t op;
    logic [1:0]           ph;
    logic [3:0]           bitn;
    logic [7:0]           sh;
    logic                 ackv;
    logic                 scl_low;
    logic                 sda_low;
    logic                 done;
    logic                 ackr;
  } st_t;
  st_t st_reg;
  st_t st_next;

  always_comb begin
    st_next = st_reg;
    st_next.done = 1'b0;
    if (st_reg.op == eeprom_i2c_pkg::BOP_NONE) begin
      if (cmd_valid_in) begin
        st_next.op = cmd_in;
        st_next.ph = 2'h0;
        st_next.bitn = 4'h0;
        st_next.sh = tx_in;
        st_next.ackv = ack_tx_in;
      end
    end else if (tick_in) begin
      st_next.ph = st_reg.ph + 2'h1;
      case (st_reg.op)
        eeprom_i2c_pkg::BOP_START: begin
          // sda released, scl high, then sda low with scl high
          case (st_reg.ph)
            2'h0: st_next.sda_low = 1'b0;
            2'h1: st_next.scl_low = 1'b0;
            2'h2: st_next.sda_low = 1'b1;
            default: begin
              st_next.scl_low = 1'b1;
              st_next.op = eeprom_i2c_pkg::BOP_NONE;
              st_next.done = 1'b1;
            end
          endcase
        end
        eeprom_i2c_pkg::BOP_STOP: begin
          case (st_reg.ph)
            2'h0: st_next.sda_low = 1'b1;
            2'h1: st_next.scl_low = 1'b0;
            2'h2: st_next.sda_low = 1'b0;
            default: begin
              st_next.op = eeprom_i2c_pkg::BOP_NONE;
              st_next.done = 1'b1;
            end
          endcase
        end
        default: begin
          case (st_reg.ph)
            2'h0: begin
              // data set while scl low, msb first; ninth bit is ack
              if (st_reg.op == eeprom_i2c_pkg::BOP_WRITE) begin
                st_next.sda_low = (st_reg.bitn == eeprom_i2c_pkg::LAST_BIT)
                                  ? 1'b0 : !st_reg.sh[7];
              end else begin
                st_next.sda_low = (st_reg.bitn == eeprom_i2c_pkg::LAST_BIT)
                                  ? st_reg.ackv : 1'b0;
              end
            end
            2'h1: st_next.scl_low = 1'b0;
            2'h2: begin
              if (st_reg.bitn == eeprom_i2c_pkg::LAST_BIT) begin
                st_next.ackr = !sda_in;
              end else begin
                st_next.sh = {st_reg.sh[6:0], sda_in};
              end
            end
            default: begin
              st_next.scl_low = 1'b1;
              st_next.bitn = st_reg.bitn + 4'h1;
              if (st_reg.bitn == eeprom_i2c_pkg::LAST_BIT) begin
                st_next.op = eeprom_i2c_pkg::BOP_NONE;
                st_next.done = 1'b1;
              end
            end
          endcase
        end
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      st_reg <= '{op: eeprom_i2c_pkg::BOP_NONE, default: '0};
    end else begin
      st_reg <= st_next;
    end
  end

  assign busy_out   = (st_reg.op != eeprom_i2c_pkg::BOP_NONE);
  assign done_out   = st_reg.done;
  assign rx_out     = st_reg.sh;
  assign ack_rx_out = st_reg.ackr;
  assign scl_oe_out = st_reg.scl_low;
  assign sda_oe_out = st_reg.sda_low;
endmodule : i2c_bit_engine

//--- i2c_tick_gen.sv
// quarter-bit enable divider for the scl timing
`timescale 1ns/100ps
module i2c_tick_gen #(
  parameter int unsigned DIV = eeprom_i2c_pkg::QTR_CYCLES
) (
  input  wire logic clk_in,
  input  wire logic rst_b_in,
  input  wire logic run_in,
  output logic      tick_out
);
  typedef struct packed {
    logic [15:0] cnt;
    logic        tick;
  } st_t;
  st_t st_reg;
  st_t st_next;

  always_comb begin
    st_next = st_reg;
    st_next.tick = 1'b0;
    if (!run_in) begin
      st_next.cnt = 16'h0000;
    end else if (st_reg.cnt == 16'(DIV - 1)) begin
      st_next.cnt = 16'h0000;
      st_next.tick = 1'b1;
    end else begin
      st_next.cnt = st_reg.cnt + 16'h0001;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign tick_out = st_reg.tick;
endmodule : i2c_tick_gen
